// ---- rtl/sar_adc_sequencer_control.sv ----
// How it works
// - bit 15 on runs the converter; off stops all sampling and conversion.
// - with idle_stop set, sampling and triggering halt while the device idles; conversions of already sampled channels still complete.
// - dma_build_order picks conversion-order or input-indexed scatter/gather dma addresses.
// - resolution_select 1 gives 12-bit single channel, 0 gives 10-bit one, two or four channels by chps.
// - 10-bit results use one of four 16-bit layouts by output_format.
// - 12-bit results use the same four codes with 12-bit layouts.
// - trigger code picks counter, external pin edge, software clear; 110 never fires.
// - codes 010/100 use timer compares, 011/101 the two pwm events.
// - scan mode converts selected inputs on sample_hold_zero in ascending order.
// - simultaneous mode samples channels together then converts each; default is sequential.
// - each sample picks set a or set b, optionally alternating per sequence.
// - up to 32 analog inputs route onto four sample-and-hold channels 0..3.
// - without dma, results fill a 16-word buffer, locations 0..F.
// - with dma, one result word and a request move each result out.
// - stored raw results are formatted at the moment they are read.
// - result storage has no reset; contents stay undefined until written.
// - dma_results_per_input sets scatter/gather results held per analog input.
// - pin_analog_config chooses analog or digital per pin.
// - auto_sample_start re-arms sampling after each sequence; otherwise software sets it.
// - done sets on completion, clears on new start or software zero write.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "adc_seq_defines.svh"
module sar_adc_sequencer_control
#(
  parameter int ADDR_W    = 12,
  parameter bit HAS_DMA   = 1'b0,
  parameter int BUF_DEPTH = 16
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic       [ADDR_W-1:0] paddr,
  input  wire logic             [31:0] pwdata,
  output logic                  [31:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    idle_mode,
  input  wire logic                    external_trigger_pin,
  input  wire logic                    timer_a_match,
  input  wire logic                    timer_b_match,
  input  wire logic                    pwm_one_event,
  input  wire logic                    pwm_two_event,
  input  wire adc_seq_pkg::conv_res_t  conv_res,
  output adc_seq_pkg::conv_req_t       conv_req,
  output logic                   [3:0] sample_hold_en,
  output logic                  [31:0] pin_analog_en,
  output adc_seq_pkg::dma_req_t        dma_req
);
  import adc_seq_pkg::*;

  localparam int IDX_W = $clog2(BUF_DEPTH);

  function automatic logic [4:0] next_scan(input logic [31:0] mask, input logic [4:0] cur);
    logic [4:0] pick;
    logic       found;
    logic [4:0] cand;
    pick  = cur;
    found = 1'b0;
    for (int i = 1; i <= 32; i++)
    begin
      cand = 5'(cur + 5'(i));
      if (!found && mask[cand])
      begin
        pick  = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  logic       [15:0] ctrl_one_r;
  logic        [3:0] mode_r;
  logic       [31:0] input_sel_r;
  logic       [31:0] scan_sel_r;
  logic       [31:0] pin_cfg_r;
  logic        [2:0] dma_per_r;
  logic        [4:0] sample_time_r;
  logic              sample_active_r,   sample_active_nxt;
  logic              done_r,   done_nxt;
  seq_state_t        st_r,     st_nxt;
  logic        [1:0] chan_r,   chan_nxt;
  logic        [4:0] cnt_r,    cnt_nxt;
  logic              use_b_r,  use_b_nxt;
  logic        [4:0] scan_r,   scan_nxt;
  logic  [IDX_W-1:0] wptr_r;
  logic        [6:0] sub_r;
  logic              pready_r;
  logic       [11:0] buf_mem [BUF_DEPTH];
  logic              start, store, seq_end, hw_set, hw_clr;

  // register bus decode
  wire logic        acc      = psel & penable & ~pready_r;
  wire logic        xfer     = psel & penable & pready_r;
  wire logic        wr       = xfer & pwrite;
  wire logic [11:0] addr     = 12'(paddr);
  wire logic        res_hit  = (addr >= `OFS_RESULT_BASE) && (addr < 12'(`OFS_RESULT_BASE + 4 * (HAS_DMA ? 1 : BUF_DEPTH)));
  wire logic        reg_hit  = (addr[1:0] == 2'h0) && (addr <= `OFS_STATUS || res_hit);
  wire logic        wr_one   = wr && addr == `OFS_CTRL_ONE;

  // field views
  wire logic        on       = ctrl_one_r[`B_ON];
  wire logic        on_nxt   = wr_one ? pwdata[`B_ON] : on;
  wire logic        res12    = ctrl_one_r[`B_RES];
  wire logic        auto_sample_start     = ctrl_one_r[`B_AUTO_SAMPLE_START];
  wire logic        simsam   = ctrl_one_r[`B_SIMSAM] & ~res12;
  wire trig_src_t   ssrc     = trig_src_t'(ctrl_one_r[`F_SSRC_LSB +: 3]);
  wire format_t     form     = format_t'(ctrl_one_r[`F_FORM_LSB +: 2]);
  wire logic [1:0]  chps     = mode_r[`F_CHPS_LSB +: 2];
  wire logic        halt     = ctrl_one_r[`B_IDLE_STOP] & idle_mode;
  wire logic        run      = on & ~halt;
  wire logic [1:0]  last_ch  = res12 ? 2'h0 : (chps == 2'h0) ? 2'h0 : (chps == 2'h1) ? 2'h1 : 2'h3;

  // trigger decode; the pin edge uses the previous sample
  logic ext_q;
  wire logic ext_edge = external_trigger_pin & ~ext_q;
  wire logic cnt_done = cnt_r >= sample_time_r;
  wire logic trig = (ssrc == TRG_SW)    ? ~sample_active_r :
                    (ssrc == TRG_EXT)   ? ext_edge :
                    (ssrc == TRG_COUNT) ? cnt_done :
                    (ssrc == TRG_TMR_A) ? timer_a_match :
                    (ssrc == TRG_TMR_B) ? timer_b_match :
                    (ssrc == TRG_PWM1)  ? pwm_one_event :
                    (ssrc == TRG_PWM2)  ? pwm_two_event : 1'b0;

  // input selection per sample-and-hold channel
  wire logic [4:0] set_zero = use_b_r ? input_sel_r[20:16] : input_sel_r[4:0];
  wire logic [4:0] set_rest = use_b_r ? input_sel_r[28:24] : input_sel_r[12:8];
  wire logic [4:0] ch0_in   = mode_r[`B_SCAN] ? scan_r : set_zero;
  wire logic [4:0] req_in   = (chan_nxt == 2'h0) ? ch0_in : 5'(set_rest + 5'(chan_nxt) - 5'h1);

  always_comb
  begin
    st_nxt   = st_r;
    chan_nxt = chan_r;
    cnt_nxt  = cnt_r;
    start    = 1'b0;
    store    = 1'b0;
    seq_end  = 1'b0;
    hw_set   = 1'b0;
    hw_clr   = 1'b0;
    unique case (st_r)
      S_IDLE:
        if (run && sample_active_r)
        begin
          st_nxt   = S_SAMPLE;
          chan_nxt = 2'h0;
          cnt_nxt  = 5'h00;
        end
      S_SAMPLE:
        if (run)
        begin
          cnt_nxt = cnt_done ? cnt_r : 5'(cnt_r + 5'h01);
          if (trig)
          begin
            st_nxt = S_CONVERT;
            start  = 1'b1;
            hw_clr = ssrc != TRG_SW;
          end
        end
      S_CONVERT:
        if (conv_res.done)
        begin
          store   = 1'b1;
          cnt_nxt = 5'h00;
          if (chan_r == last_ch)
          begin
            seq_end  = 1'b1;
            chan_nxt = 2'h0;
            st_nxt   = auto_sample_start ? S_SAMPLE : S_IDLE;
            hw_set   = auto_sample_start;
          end
          else
          begin
            chan_nxt = 2'(chan_r + 2'h1);
            // simultaneous: every channel already holds, convert the next at once
            if (simsam)
              start = 1'b1;
            else
            begin
              st_nxt = S_SAMPLE;
              hw_set = 1'b1;
            end
          end
        end
    endcase
    if (!on)
    begin
      st_nxt   = S_IDLE;
      chan_nxt = 2'h0;
      start    = 1'b0;
    end
  end

  // sample_active: hardware set/clear, software writes gated by mode
  always_comb
  begin
    sample_active_nxt = sample_active_r;
    if (wr_one && pwdata[`B_SAMPLE_ACTIVE] && !auto_sample_start)
      sample_active_nxt = 1'b1;
    if (wr_one && !pwdata[`B_SAMPLE_ACTIVE] && ssrc == TRG_SW)
      sample_active_nxt = 1'b0;
    if (hw_clr)
      sample_active_nxt = 1'b0;
    if (hw_set)
      sample_active_nxt = 1'b1;
    // the write that turns the converter on may set sample_active in the same access
    if (!on_nxt)
      sample_active_nxt = 1'b0;
  end

  // set wins over both clears
  assign done_nxt = seq_end ? 1'b1 :
                    start ? 1'b0 :
                    (wr_one && !pwdata[`B_DONE]) ? 1'b0 : done_r;

  assign use_b_nxt = (!on || !mode_r[`B_ALT]) ? 1'b0 : (seq_end ? ~use_b_r : use_b_r);
  assign scan_nxt  = !on ? next_scan(scan_sel_r, 5'h1F) :
                     (seq_end && mode_r[`B_SCAN]) ? next_scan(scan_sel_r, scan_r) : scan_r;

  // dma addressing
  wire logic [11:0] sg_addr  = 12'(({7'h00, conv_req.ain} << dma_per_r) + {5'h00, sub_r});
  wire logic [11:0] ord_addr = 12'(wptr_r);
  wire logic [6:0]  sub_max  = 7'((8'h01 << dma_per_r) - 8'h01);

  // result read path
  wire logic [IDX_W-1:0] rd_idx = HAS_DMA ? '0 : addr[2 +: IDX_W];
  logic [15:0] fmt_word;

  result_formatter u_fmt
  (
    .raw   (buf_mem[rd_idx]),
    .res12 (res12),
    .form  (form),
    .dout  (fmt_word)
  );

  wire logic [15:0] ctrl_one_rd = (ctrl_one_r & `CTRL_ONE_MASK & ~16'h0003)
                                | {15'h0000, done_r} | {14'h0000, sample_active_r, 1'b0};
  wire logic [31:0] rdata = res_hit ? {16'h0000, fmt_word} :
                            (addr == `OFS_CTRL_ONE)    ? {16'h0000, ctrl_one_rd} :
                            (addr == `OFS_CTRL_MODE)   ? {28'h000_0000, mode_r} :
                            (addr == `OFS_INPUT_SEL)   ? (input_sel_r & 32'h1F1F_1F1F) :
                            (addr == `OFS_SCAN_SEL)    ? scan_sel_r :
                            (addr == `OFS_PIN_CFG)     ? pin_cfg_r :
                            (addr == `OFS_DMA_PER)     ? {29'h0000_0000, dma_per_r} :
                            (addr == `OFS_SAMPLE_TIME) ? {27'h000_0000, sample_time_r} :
                            (addr == `OFS_STATUS)      ? {19'h0_0000, use_b_r, 2'h0, chan_r, 3'h0, scan_r} :
                                                         32'h0000_0000;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready_r <= 1'b0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= acc;
      pready   <= acc;
      pslverr  <= acc & ~reg_hit;
      prdata   <= acc ? rdata : prdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_one_r    <= `RST_CTRL_ONE;
      mode_r        <= `RST_MODE;
      input_sel_r   <= `RST_INPUT_SEL;
      scan_sel_r    <= `RST_SCAN_SEL;
      pin_cfg_r     <= `RST_PIN_CFG;
      dma_per_r     <= `RST_DMA_PER;
      sample_time_r <= `RST_SAMPLE_TIME;
    end
    else if (wr)
    begin
      // writing resolution 1 also forces the simultaneous bit to read zero
      if (addr == `OFS_CTRL_ONE)
        ctrl_one_r <= pwdata[15:0] & `CTRL_ONE_MASK & ~16'h0003
                      & ~({12'h000, pwdata[`B_RES], 3'h0});
      if (addr == `OFS_CTRL_MODE)
        mode_r <= pwdata[3:0];
      if (addr == `OFS_INPUT_SEL)
        input_sel_r <= pwdata & 32'h1F1F_1F1F;
      if (addr == `OFS_SCAN_SEL)
        scan_sel_r <= pwdata;
      if (addr == `OFS_PIN_CFG)
        pin_cfg_r <= pwdata;
      if (addr == `OFS_DMA_PER)
        dma_per_r <= pwdata[2:0];
      if (addr == `OFS_SAMPLE_TIME)
        sample_time_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r    <= S_IDLE;
      chan_r  <= 2'h0;
      cnt_r   <= 5'h00;
      sample_active_r  <= 1'b0;
      done_r  <= 1'b0;
      use_b_r <= 1'b0;
      scan_r  <= 5'h00;
      ext_q   <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      chan_r  <= chan_nxt;
      cnt_r   <= cnt_nxt;
      sample_active_r  <= sample_active_nxt;
      done_r  <= done_nxt;
      use_b_r <= use_b_nxt;
      scan_r  <= scan_nxt;
      ext_q   <= external_trigger_pin;
    end
  end

  // outputs to the analog core, pins and dma
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      conv_req       <= '0;
      sample_hold_en <= 4'h0;
      pin_analog_en  <= 32'hFFFF_FFFF;
      dma_req        <= '0;
      wptr_r         <= '0;
      sub_r          <= 7'h00;
    end
    else
    begin
      conv_req.start <= start;
      if (start)
      begin
        conv_req.chan <= chan_nxt;
        conv_req.ain  <= req_in;
      end
      sample_hold_en <= (st_nxt != S_SAMPLE) ? 4'h0 :
                        simsam ? 4'(4'hF >> (2'h3 - last_ch)) : 4'(4'h1 << chan_nxt);
      pin_analog_en  <= ~pin_cfg_r;
      dma_req.req    <= HAS_DMA & store;
      if (store)
        dma_req.addr <= ctrl_one_r[`B_DMA_ORDER] ? ord_addr : sg_addr;
      wptr_r <= !on ? '0 : (store ? IDX_W'(wptr_r + 1'b1) : wptr_r);
      sub_r  <= !on ? 7'h00 : (seq_end ? ((sub_r >= sub_max) ? 7'h00 : 7'(sub_r + 7'h01)) : sub_r);
    end
  end

  // result storage deliberately has no reset
  always_ff @(posedge clk_sys)
  begin
    if (store)
      buf_mem[HAS_DMA ? '0 : wptr_r] <= conv_res.data;
  end

  sequence s_trig_fire;
    st_r == S_SAMPLE && run && trig;
  endsequence

  sequence s_seq_done;
    st_r == S_CONVERT && conv_res.done && chan_r == last_ch && on;
  endsequence

  chk_off_stops_all: assert property (@(posedge clk_sys) disable iff (rst)
    !on |=> st_r == S_IDLE && !conv_req.start && (on || !sample_active_r))
    else $error("converter off but sequencer active");

  chk_idle_halt_hold: assert property (@(posedge clk_sys) disable iff (rst)
    st_r == S_SAMPLE && halt && on |=> st_r == S_SAMPLE && !conv_req.start)
    else $error("sampling advanced while halted in idle");

  chk_trig_starts_conv: assert property (@(posedge clk_sys) disable iff (rst)
    s_trig_fire |=> conv_req.start && !done_r && st_r == S_CONVERT)
    else $error("trigger did not start a conversion");

  chk_rsvd_no_trig: assert property (@(posedge clk_sys) disable iff (rst)
    st_r == S_SAMPLE && ssrc == TRG_RSVD && on |=> !conv_req.start)
    else $error("reserved trigger code started a conversion");

  chk_done_on_end: assert property (@(posedge clk_sys) disable iff (rst)
    s_seq_done |=> done_r ##1 (done_r || conv_req.start || $past(wr_one)))
    else $error("done not set at end of sequence");

  chk_auto_rearm: assert property (@(posedge clk_sys) disable iff (rst)
    s_seq_done ##0 auto_sample_start |=> sample_active_r && st_r == S_SAMPLE)
    else $error("auto sample start did not re-arm");

  chk_single_chan12: assert property (@(posedge clk_sys) disable iff (rst)
    res12 && conv_req.start |-> conv_req.chan == 2'h0)
    else $error("12-bit mode converted a channel other than zero");

  chk_dma_request: assert property (@(posedge clk_sys) disable iff (rst)
    HAS_DMA && st_r == S_CONVERT && conv_res.done && on |=> dma_req.req ##1 !dma_req.req)
    else $error("dma request not a single pulse after a result");

  chk_sim_back2back: assert property (@(posedge clk_sys) disable iff (rst)
    st_r == S_CONVERT && conv_res.done && simsam && chan_r != last_ch && on
    |=> conv_req.start && conv_req.chan == $past(chan_r) + 2'h1)
    else $error("simultaneous mode did not convert the next channel");

endmodule

// ---- rtl/adc_seq_defines.svh ----
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register byte offsets
`define OFS_CTRL_ONE      12'h000
`define OFS_CTRL_MODE     12'h004
`define OFS_INPUT_SEL     12'h008
`define OFS_SCAN_SEL      12'h00C
`define OFS_PIN_CFG       12'h010
`define OFS_DMA_PER       12'h014
`define OFS_SAMPLE_TIME   12'h018
`define OFS_STATUS        12'h01C
`define OFS_RESULT_BASE   12'h040

// converter_control_one fields
`define B_ON              15
`define B_IDLE_STOP       13
`define B_DMA_ORDER       12
`define B_RES             10
`define F_FORM_LSB        8
`define F_SSRC_LSB        5
`define B_SIMSAM          3
`define B_AUTO_SAMPLE_START            2
`define B_SAMPLE_ACTIVE            1
`define B_DONE            0
`define CTRL_ONE_MASK     16'hB7EF

// mode register fields
`define B_ALT             0
`define B_SCAN            1
`define F_CHPS_LSB        2

// reset values
`define RST_CTRL_ONE      16'h0000
`define RST_MODE          4'h0
`define RST_INPUT_SEL     32'h0000_0000
`define RST_SCAN_SEL      32'h0000_0000
`define RST_PIN_CFG       32'h0000_0000
`define RST_DMA_PER       3'h0
`define RST_SAMPLE_TIME   5'h01

`endif

// ---- rtl/adc_seq_pkg.sv ----
package adc_seq_pkg;

  typedef enum logic [1:0] {FMT_INT, FMT_SINT, FMT_FRAC, FMT_SFRAC} format_t;

  typedef enum logic [2:0] {TRG_SW, TRG_EXT, TRG_TMR_A, TRG_PWM1,
                            TRG_TMR_B, TRG_PWM2, TRG_RSVD, TRG_COUNT} trig_src_t;

  typedef enum {S_IDLE, S_SAMPLE, S_CONVERT} seq_state_t;

  typedef struct packed {
    logic       start;
    logic [1:0] chan;
    logic [4:0] ain;
  } conv_req_t;

  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } conv_res_t;

  typedef struct packed {
    logic        req;
    logic [11:0] addr;
  } dma_req_t;

endpackage

// ---- rtl/result_formatter.sv ----
`timescale 1ns/100ps
module result_formatter
(
  input  wire logic                  [11:0] raw,
  input  wire logic                         res12,
  input  wire adc_seq_pkg::format_t         form,
  output logic                       [15:0] dout
);
  import adc_seq_pkg::*;

  // raw codes are offset binary, so the sign is the inverted msb
  wire logic        sign10 = ~raw[9];
  wire logic        sign12 = ~raw[11];
  wire logic [15:0] d10;
  wire logic [15:0] d12;

  assign d10 = (form == FMT_SFRAC) ? {sign10, raw[8:0], 6'h00} :
               (form == FMT_FRAC)  ? {raw[9:0], 6'h00} :
               (form == FMT_SINT)  ? {{7{sign10}}, raw[8:0]} :
                                     {6'h00, raw[9:0]};
  assign d12 = (form == FMT_SFRAC) ? {sign12, raw[10:0], 4'h0} :
               (form == FMT_FRAC)  ? {raw, 4'h0} :
               (form == FMT_SINT)  ? {{5{sign12}}, raw[10:0]} :
                                     {4'h0, raw};
  assign dout = res12 ? d12 : d10;

endmodule

// ---- tb/analog_core_model.sv ----
`timescale 1ns/100ps
module analog_core_model
  import adc_seq_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire logic      slow,
  input  wire conv_req_t conv_req,
  output conv_res_t      conv_res
);
  logic        busy_r;
  logic        done_r;
  logic [4:0]  cnt_r;
  logic [11:0] junk_r;
  // data is only valid with done; otherwise a moving pattern so no stale value passes
  assign conv_res = {done_r, done_r ? 12'h2A5 : junk_r};
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r  <= 5'h00;
      junk_r <= 12'hC3A;
    end
    else
    begin
      junk_r <= junk_r + 12'h3B7;
      done_r <= 1'b0;
      if (conv_req.start)
      begin
        busy_r <= 1'b1;
        cnt_r  <= slow ? 5'h14 : 5'h02;
      end
      else if (busy_r && cnt_r == 5'h00)
      begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 5'h01;
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import adc_seq_pkg::*;
  logic        clk_sys, rst, psel, penable, pwrite, idle_mode, slow;
  logic        pready, pslverr, e, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pin_analog_en, q;
  logic [4:0]  ev;
  logic [3:0]  sample_hold_en;
  conv_req_t   conv_req;
  conv_res_t   conv_res;
  dma_req_t    dma_req;
  int          failures = 0, checked = 0, starts = 0, mark;
  logic [4:0]  ains[$];
  logic [4:0]  aexp [8] = '{5'h03, 5'h0A, 5'h0B, 5'h0C, 5'h05, 5'h14, 5'h15, 5'h16};
  logic [15:0] fexp [8] = '{16'h02A5, 16'h00A5, 16'hA940, 16'h2940,
                           16'h02A5, 16'hFAA5, 16'h2A50, 16'hAA50};
  sar_adc_sequencer_control i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .external_trigger_pin(ev[0]), .timer_a_match(ev[1]),
    .pwm_one_event(ev[2]), .timer_b_match(ev[3]), .pwm_two_event(ev[4]), .conv_res(conv_res),
    .conv_req(conv_req), .sample_hold_en(sample_hold_en), .pin_analog_en(pin_analog_en),
    .dma_req(dma_req));
  analog_core_model i_core (.clk_sys(clk_sys), .rst(rst), .slow(slow), .conv_req(conv_req),
    .conv_res(conv_res));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (conv_req.start === 1'b1)
    begin
      starts <= starts + 1;
      ains.push_back(conv_req.ain);
    end
  task give_verdict();
    $display("counts: checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one setup cycle, then access held until pready is seen at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // checks for any conversion start since mark, taken before the stimulus
  task expect_start(input int lim, input logic want);
    hit = 1'b0;
    repeat (lim)
    begin
      @(posedge clk_sys);
      if (starts != mark)
        hit = 1'b1;
    end
    `CHK(hit, want)
  endtask
  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; idle_mode = 1'b0; slow = 1'b0; ev = 5'h00; q = 32'h0000_0000;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h000); `CHK(q, 32'h0000_0000)
    rd(12'h018); `CHK(q, 32'h0000_0001)
    `CHK(pin_analog_en, 32'hFFFF_FFFF)
    wr(12'h000, 32'h0000_7FFD); rd(12'h000); `CHK(q, 32'h0000_37E4)
    wr(12'h000, 32'h0000_0000);
    rd(12'h080); `CHK(e, 1'b1)
    wr(12'h010, 32'h0000_00F0); rd(12'h010); `CHK(pin_analog_en, 32'hFFFF_FF0F)
    $display("test registers done");
    mark = starts; wr(12'h000, 32'h0000_00E2); expect_start(30, 1'b0);
    $display("test off done");
    slow <= 1'b1;
    mark = starts; wr(12'h000, 32'h0000_80E2); expect_start(30, 1'b1);
    q = 32'h0000_0000;
    for (int i = 0; i < 20 && q[0] !== 1'b1; i++)
      rd(12'h000);
    `CHK(q[0], 1'b1)
    // one stored sample, read back in every layout: formatting happens at read time
    for (int k = 0; k < 8; k++)
    begin
      wr(12'h000, 32'h0000_8000 | (32'(k) << 8));
      rd(12'h040); `CHK(q, {16'h0000, fexp[k]})
    end
    wr(12'h000, 32'h0000_0000);
    slow <= 1'b0;
    $display("test formats done");
    for (int c = 0; c < 7; c++)
    begin
      mark = starts; wr(12'h000, 32'h0000_8002 | (32'(c) << 5)); expect_start(5, 1'b0);
      mark = starts;
      if (c == 0)
        wr(12'h000, 32'h0000_8000);
      else
        ev <= (c == 6) ? 5'h1F : 5'(1 << (c - 1));
      expect_start(20, c != 6);
      ev <= 5'h00;
      wr(12'h000, 32'h0000_0000);
    end
    $display("test triggers done");
    idle_mode <= 1'b1;
    mark = starts; wr(12'h000, 32'h0000_A0E2); expect_start(30, 1'b0);
    mark = starts; idle_mode <= 1'b0; expect_start(30, 1'b1);
    wr(12'h000, 32'h0000_0000);
    idle_mode <= 1'b1;
    mark = starts; wr(12'h000, 32'h0000_80E2); expect_start(30, 1'b1);
    idle_mode <= 1'b0;
    wr(12'h000, 32'h0000_0000);
    $display("test idle done");
    wr(12'h004, 32'h0000_0002); wr(12'h00C, 32'h0000_0014);
    ains.delete();
    wr(12'h000, 32'h0000_80E6);
    for (int i = 0; i < 300 && ains.size() < 3; i++)
      @(posedge clk_sys);
    `CHK(ains[0], 5'd2)
    `CHK(ains[1], 5'd4)
    `CHK(ains[2], 5'd2)
    wr(12'h000, 32'h0000_0000);
    $display("test scan done");
    // four channels sampled together, set a then set b on alternate sequences
    wr(12'h004, 32'h0000_000D); wr(12'h008, 32'h1405_0A03);
    ains.delete();
    wr(12'h000, 32'h0000_80EE);
    for (int i = 0; i < 10 && sample_hold_en !== 4'hF; i++)
      @(posedge clk_sys);
    `CHK(sample_hold_en, 4'hF)
    for (int i = 0; i < 300 && ains.size() < 8; i++)
      @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
      `CHK(ains[i], aexp[i])
    `CHK(dma_req.req, 1'b0)
    wr(12'h000, 32'h0000_0000);
    $display("test simultaneous done");
    give_verdict();
  end
endmodule
